// ### rtl/sleep_pkg.sv
// Shared constants and carriers for the sleep-mode controller.
package sleep_pkg;
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_QUIET = 3'h1;
    localparam logic [2:0] MODE_DOWN = 3'h2;
    localparam logic [2:0] MODE_SAVE = 3'h3;
    localparam logic [2:0] MODE_STBY = 3'h6;
    localparam logic [2:0] MODE_XSTBY = 3'h7;
    localparam int HALT_CYCLES = 4;
    localparam int STBY_WAKE_CYCLES = 6;
    localparam int CLK_PERIOD_NS = 10;
    // Oscillator restart time-out in microseconds (configurable default).
    localparam int OSC_TIMEOUT_US = 64;
    localparam int OSC_TIMEOUT_CYC = OSC_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam logic [2:0] HALT_W = 3'(HALT_CYCLES);
    localparam logic [2:0] STBY_W = 3'(STBY_WAKE_CYCLES);

    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_SLEEP = 3'h1,
        ST_START = 3'h2,
        ST_HALT = 3'h3
    } state_e;

    // Wake sources presented by peripherals.
    typedef struct packed {
        logic ext_level;
        logic ext_edge;
        logic pin_change;
        logic twi_match;
        logic timer2;
        logic mem_ready;
        logic conv_done;
        logic wdt_irq;
        logic other_io;
    } wake_s;

    // Clock-domain enables.
    typedef struct packed {
        logic core_clock;
        logic program_memory_clock;
        logic peripheral_clock;
        logic converter_clock;
        logic async_timer_clock;
        logic main_osc;
        logic timer_osc;
    } clk_en_s;
endpackage

// ### rtl/sleep_mode_controller.sv
// Sleep-mode controller: clock gating, wake-up and start-up sequencing.
`timescale 1ns/1ns
module sleep_mode_controller #(
    parameter int OSC_TIMEOUT = sleep_pkg::OSC_TIMEOUT_CYC
) (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // Core interface
    input wire logic i_sleep_op,
    input wire logic i_sleep_enable_bit,
    input wire logic [2:0] i_sleep_mode_selector,
    input wire logic i_any_reset,
    input wire logic i_global_irq_en,
    // Configuration
    input wire logic i_xtal_selected,
    input wire logic i_conv_enabled,
    input wire logic i_timer2_enabled,
    input wire logic i_timer2_async,
    input wire logic i_timer2_irq_mask,
    // Wake sources
    input wire sleep_pkg::wake_s i_wake,
    // Outputs
    output sleep_pkg::clk_en_s o_clk_en,
    output logic o_core_hold,
    output logic o_irq_take,
    output logic o_reset_vector,
    output logic o_conv_start,
    output logic o_sleeping
);
    // ************************************************************
    // State
    // ************************************************************
    localparam int CW = $clog2(OSC_TIMEOUT + 1);
    localparam logic [CW-1:0] OSC_W = CW'(OSC_TIMEOUT);

    typedef struct packed {
        sleep_pkg::state_e st;
        logic [2:0] mode;
        logic [CW-1:0] cnt;
        logic irq_pend;
        sleep_pkg::clk_en_s clk;
        logic hold;
        logic irq_take;
        logic rst_vec;
        logic conv;
        logic sleeping;
    } state_s;

    localparam sleep_pkg::clk_en_s ALL_ON = '1;
    state_s s_r, s_nxt;

    // ************************************************************
    // Mode decoding
    // ************************************************************
    // defined codes only
    function automatic logic mode_valid(input logic [2:0] m);
        case (m)
            sleep_pkg::MODE_IDLE, sleep_pkg::MODE_QUIET,
            sleep_pkg::MODE_DOWN, sleep_pkg::MODE_SAVE:
                mode_valid = 1'b1;
            sleep_pkg::MODE_STBY, sleep_pkg::MODE_XSTBY:
                mode_valid = i_xtal_selected;
            default: mode_valid = 1'b0;
        endcase
    endfunction

    function automatic sleep_pkg::clk_en_s mode_clocks(input logic [2:0] m);
        sleep_pkg::clk_en_s c;
        logic t2s;
        logic t2a;
        c = '0;
        t2s = i_timer2_enabled && !i_timer2_async;
        t2a = i_timer2_enabled && i_timer2_async;
        case (m)
            sleep_pkg::MODE_IDLE: begin
                c = ALL_ON;
                c.core_clock = 1'b0;
                c.program_memory_clock = 1'b0;
            end
            sleep_pkg::MODE_QUIET: begin
                c.converter_clock = 1'b1;
                c.async_timer_clock = 1'b1;
                c.main_osc = 1'b1;
                c.timer_osc = t2a;
            end
            sleep_pkg::MODE_SAVE: begin
                c.async_timer_clock = t2a;
                c.timer_osc = t2a;
                c.main_osc = t2s;
            end
            sleep_pkg::MODE_STBY: c.main_osc = 1'b1;
            sleep_pkg::MODE_XSTBY: begin
                c.async_timer_clock = t2a;
                c.timer_osc = t2a;
                c.main_osc = 1'b1;
            end
            default: c = '0;
        endcase
        mode_clocks = c;
    endfunction

    // Interrupt wake allowed in mode; level-only rule for deep states.
    function automatic logic mode_wake(input logic [2:0] m,
                                       input sleep_pkg::wake_s w);
        logic t2;
        logic base;
        t2 = w.timer2 && i_timer2_irq_mask && i_global_irq_en;
        base = w.ext_level | w.pin_change | w.twi_match | w.wdt_irq;
        case (m)
            sleep_pkg::MODE_IDLE: mode_wake = base | w.ext_edge |
                w.timer2 | w.mem_ready | w.conv_done | w.other_io;
            sleep_pkg::MODE_QUIET: mode_wake = base |
                (w.timer2 & i_timer2_async) | w.mem_ready | w.conv_done;
            sleep_pkg::MODE_SAVE, sleep_pkg::MODE_XSTBY:
                mode_wake = base | t2;
            default: mode_wake = base;
        endcase
    endfunction

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.conv = 1'b0;
        s_nxt.irq_take = 1'b0;
        s_nxt.rst_vec = 1'b0;
        case (s_r.st)
            sleep_pkg::ST_RUN: begin
                s_nxt.hold = 1'b0;
                s_nxt.clk = ALL_ON;
                if (i_sleep_op && i_sleep_enable_bit &&
                    mode_valid(i_sleep_mode_selector) && !i_any_reset) begin
                    s_nxt.st = sleep_pkg::ST_SLEEP;
                    s_nxt.mode = i_sleep_mode_selector;
                    s_nxt.clk = mode_clocks(i_sleep_mode_selector);
                    s_nxt.conv = i_conv_enabled &&
                        i_sleep_mode_selector == sleep_pkg::MODE_QUIET;
                end
            end
            sleep_pkg::ST_SLEEP: begin
                if (i_any_reset) begin
                    s_nxt.st = sleep_pkg::ST_RUN;
                    s_nxt.clk = ALL_ON;
                    s_nxt.rst_vec = 1'b1;
                end else if (mode_wake(s_r.mode, i_wake)) begin
                    s_nxt.st = sleep_pkg::ST_START;
                    s_nxt.clk.main_osc = 1'b1;
                    s_nxt.irq_pend = 1'b1;
                    if (s_r.mode == sleep_pkg::MODE_DOWN ||
                        s_r.mode == sleep_pkg::MODE_SAVE)
                        s_nxt.cnt = OSC_W;
                    else if (s_r.mode == sleep_pkg::MODE_STBY ||
                             s_r.mode == sleep_pkg::MODE_XSTBY)
                        s_nxt.cnt = CW'(sleep_pkg::STBY_W);
                    else
                        s_nxt.cnt = '0;
                end
            end
            sleep_pkg::ST_START: begin
                if (i_any_reset) begin
                    s_nxt.st = sleep_pkg::ST_RUN;
                    s_nxt.clk = ALL_ON;
                    s_nxt.rst_vec = 1'b1;
                end else if (s_r.cnt > CW'(1)) begin
                    s_nxt.cnt = s_r.cnt - CW'(1);
                end else begin
                    // level must still stand at start-up end
                    s_nxt.irq_pend = mode_wake(s_r.mode, i_wake);
                    s_nxt.clk = ALL_ON;
                    s_nxt.st = sleep_pkg::ST_HALT;
                    s_nxt.cnt = CW'(sleep_pkg::HALT_W);
                end
            end
            sleep_pkg::ST_HALT: begin
                if (s_r.cnt > CW'(1)) begin
                    s_nxt.cnt = s_r.cnt - CW'(1);
                end else begin
                    s_nxt.st = sleep_pkg::ST_RUN;
                    s_nxt.hold = 1'b0;
                    s_nxt.irq_take = s_r.irq_pend;
                    s_nxt.irq_pend = 1'b0;
                end
            end
            default: s_nxt.st = sleep_pkg::ST_RUN;
        endcase
        // Hold follows the state, so a reset wake never leaves the core
        // stalled for a cycle after it is back in run.
        s_nxt.hold = (s_nxt.st != sleep_pkg::ST_RUN);
        s_nxt.sleeping = (s_nxt.st == sleep_pkg::ST_SLEEP);
    end

    // storage is cleared to run, all clocks on, by i_sys_rst
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_r <= '{st: sleep_pkg::ST_RUN, mode: 3'h0, cnt: '0,
                     irq_pend: 1'b0, clk: ALL_ON, hold: 1'b0,
                     irq_take: 1'b0, rst_vec: 1'b0, conv: 1'b0,
                     sleeping: 1'b0};
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    assign o_clk_en = s_r.clk;
    assign o_core_hold = s_r.hold;
    assign o_irq_take = s_r.irq_take;
    assign o_reset_vector = s_r.rst_vec;
    assign o_conv_start = s_r.conv;
    assign o_sleeping = s_r.sleeping;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence halt_four;
        s_r.st == sleep_pkg::ST_HALT [*4];
    endsequence

    sequence start_six;
        s_r.st == sleep_pkg::ST_START [*6];
    endsequence

    a_enable_gates_entry: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        i_ce && i_sleep_op && !i_sleep_enable_bit && s_r.st ==
        sleep_pkg::ST_RUN |=> s_r.st == sleep_pkg::ST_RUN)
        else $error("sleep entered without enable");
    a_halt_four_cycles: assert property (
        @(posedge i_clk) disable iff (i_sys_rst || !i_ce || i_any_reset)
        s_r.st == sleep_pkg::ST_HALT && $past(s_r.st) ==
        sleep_pkg::ST_START |-> halt_four ##1 s_r.st == sleep_pkg::ST_RUN)
        else $error("halt not four cycles");
    a_standby_six_wake: assert property (
        @(posedge i_clk) disable iff (i_sys_rst || !i_ce || i_any_reset)
        s_r.st == sleep_pkg::ST_START && $past(s_r.st) ==
        sleep_pkg::ST_SLEEP && s_r.mode[2:1] == 2'h3
        |-> start_six ##1 s_r.st == sleep_pkg::ST_HALT)
        else $error("standby wake not six cycles");
    a_quiet_conv_start: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        i_ce && s_r.st == sleep_pkg::ST_RUN && i_sleep_op &&
        i_sleep_enable_bit && !i_any_reset && i_conv_enabled &&
        i_sleep_mode_selector == sleep_pkg::MODE_QUIET |=> o_conv_start)
        else $error("quiet entry started no conversion");
    a_reset_vector_out: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        i_ce && i_any_reset && s_r.st == sleep_pkg::ST_SLEEP
        |=> o_reset_vector && s_r.st == sleep_pkg::ST_RUN)
        else $error("reset did not wake to vector");
    a_idle_clocks: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        o_sleeping && s_r.mode == sleep_pkg::MODE_IDLE |->
        !o_clk_en.core_clock && o_clk_en.peripheral_clock)
        else $error("idle clock gating wrong");
    a_quiet_clocks: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        o_sleeping && s_r.mode == sleep_pkg::MODE_QUIET |->
        !o_clk_en.peripheral_clock && o_clk_en.converter_clock)
        else $error("quiet clock gating wrong");
    a_down_all_off: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        o_sleeping && s_r.mode == sleep_pkg::MODE_DOWN |-> o_clk_en == '0)
        else $error("power-down clocks not stopped");
    a_edge_no_wake: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        i_ce && o_sleeping && s_r.mode != sleep_pkg::MODE_IDLE &&
        i_wake == sleep_pkg::wake_s'(9'h080) && !i_any_reset
        |=> o_sleeping)
        else $error("edge request woke deep state");
    a_reserved_no_sleep: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        i_ce && s_r.st == sleep_pkg::ST_RUN && i_sleep_mode_selector[2:1]
        == 2'h2 |=> s_r.st == sleep_pkg::ST_RUN)
        else $error("reserved code entered sleep");
endmodule

// ### verif/sleep_core_model.sv
// Core and wake-source model that drives the sleep-mode controller.
`timescale 1ns/1ns
module sleep_core_model (
    // Clock and core status
    input wire logic i_clk,
    input wire logic i_hold,
    // Core requests and wake levels
    output logic o_sleep_op,
    output logic o_sleep_enable_bit,
    output logic [2:0] o_sleep_mode_selector,
    output sleep_pkg::wake_s o_wake
);
    initial begin
        o_sleep_op = 1'b0;
        o_sleep_enable_bit = 1'b0;
        o_sleep_mode_selector = 3'h0;
        o_wake = '0;
    end

    // enable set together with the op
    // The enable is dropped together with the op so a stray op cannot sleep.
    task automatic do_sleep(input logic [2:0] mode, input logic en);
        @(negedge i_clk);
        o_sleep_op = 1'b1;
        o_sleep_enable_bit = en;
        o_sleep_mode_selector = mode;
        @(negedge i_clk);
        o_sleep_op = 1'b0;
        o_sleep_enable_bit = 1'b0;
        @(negedge i_clk);
    endtask

    // level held until release
    // A short request drops after one cycle; n counts edges until release.
    task automatic wake(input sleep_pkg::wake_s w, input bit short,
                        output int n);
        n = 0;
        o_wake = w;
        do begin
            @(negedge i_clk);
            n++;
            if (short)
                o_wake = '0;
        end while (i_hold === 1'b1 && n < 100);
        o_wake = '0;
    endtask

    task automatic hold_wake(input sleep_pkg::wake_s w, input int n);
        o_wake = w;
        repeat (n) @(negedge i_clk);
        o_wake = '0;
    endtask
endmodule

// ### verif/sleep_mode_controller_tb.sv
// Self-checking testbench for the sleep-mode controller.
`timescale 1ns/1ns
module sleep_mode_controller_tb;
    logic i_clk, i_sys_rst, i_ce, i_sleep_op, i_sleep_enable_bit;
    logic [2:0] i_sleep_mode_selector;
    logic i_any_reset, i_global_irq_en, i_xtal_selected, i_conv_enabled;
    logic i_timer2_enabled, i_timer2_async, i_timer2_irq_mask;
    sleep_pkg::wake_s i_wake;
    sleep_pkg::clk_en_s o_clk_en;
    logic o_core_hold, o_irq_take, o_reset_vector, o_conv_start, o_sleeping;
    int mismatches = 0, comparisons = 0, irqs = 0, rvs = 0, convs = 0;
    int n, i0, c0, r0;
    // ****************************************************************
    // Per-mode expectations: clocks, checked bits, start-up, wake sets
    // ****************************************************************
    logic [2:0] md[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    logic [6:0] ex[6] = '{7'h1f, 7'h0f, 7'h00, 7'h05, 7'h02, 7'h07};
    int lat[6] = '{1, 1, 8, 8, 6, 6};
    logic [8:0] gd[6] = '{9'h001, 9'h004, 9'h040, 9'h010, 9'h020, 9'h002};
    logic [8:0] bd[6] = '{9'h000, 9'h001, 9'h010, 9'h008, 9'h004, 9'h080};

    sleep_mode_controller #(.OSC_TIMEOUT(8)) dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
        .i_sleep_op(i_sleep_op), .i_sleep_enable_bit(i_sleep_enable_bit),
        .i_sleep_mode_selector(i_sleep_mode_selector),
        .i_any_reset(i_any_reset), .i_global_irq_en(i_global_irq_en),
        .i_xtal_selected(i_xtal_selected), .i_conv_enabled(i_conv_enabled),
        .i_timer2_enabled(i_timer2_enabled), .i_timer2_async(i_timer2_async),
        .i_timer2_irq_mask(i_timer2_irq_mask), .i_wake(i_wake),
        .o_clk_en(o_clk_en), .o_core_hold(o_core_hold),
        .o_irq_take(o_irq_take), .o_reset_vector(o_reset_vector),
        .o_conv_start(o_conv_start), .o_sleeping(o_sleeping));

    sleep_core_model pm (
        .i_clk(i_clk), .i_hold(o_core_hold), .o_sleep_op(i_sleep_op),
        .o_sleep_enable_bit(i_sleep_enable_bit),
        .o_sleep_mode_selector(i_sleep_mode_selector), .o_wake(i_wake));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Pulses are counted on the following edge so the count never races.
    always @(posedge i_clk) begin
        if (o_irq_take === 1'b1) irqs++;
        if (o_reset_vector === 1'b1) rvs++;
        if (o_conv_start === 1'b1) convs++;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end

    initial begin
        {i_sys_rst, i_ce, i_any_reset, i_global_irq_en} = 4'hd;
        {i_xtal_selected, i_conv_enabled, i_timer2_enabled} = 3'h7;
        {i_timer2_async, i_timer2_irq_mask} = 2'h3;
        repeat (8) @(negedge i_clk);
        i_sys_rst = 1'b0;
        chk(16'(o_clk_en), 16'h7f);
        chk(16'({o_sleeping, o_core_hold}), 16'h0);
        pm.do_sleep(3'h2, 1'b0);
        chk(16'({o_sleeping, o_core_hold, o_clk_en}), 16'h7f);
        pm.do_sleep(3'h4, 1'b1);
        chk(16'(o_sleeping), 16'h0);
        pm.do_sleep(3'h5, 1'b1);
        chk(16'(o_sleeping), 16'h0);
        i_xtal_selected = 1'b0;
        pm.do_sleep(3'h6, 1'b1);
        chk(16'(o_sleeping), 16'h0);
        i_xtal_selected = 1'b1;
        for (int k = 0; k < 6; k++) begin
            c0 = convs;
            i0 = irqs;
            pm.do_sleep(md[k], 1'b1);
            chk(16'({o_sleeping, o_core_hold}), 16'h3);
            chk(16'(o_clk_en), 16'(ex[k]));
            chk(16'(convs - c0), 16'(md[k] == 3'h1));
            pm.hold_wake(bd[k], 20);
            chk(16'(o_sleeping), 16'h1);
            @(negedge i_clk);
            pm.wake(gd[k], 1'b0, n);
            @(negedge i_clk);
            chk(16'(n), 16'(lat[k] + 5));
            chk(16'(irqs - i0), 16'h1);
            chk(16'({o_sleeping, o_clk_en}), 16'h7f);
        end
        i0 = irqs;
        i_timer2_enabled = 1'b0;
        pm.do_sleep(3'h2, 1'b1);
        pm.wake(9'h100, 1'b1, n);
        @(negedge i_clk);
        chk(16'(n), 16'h0d);
        chk(16'(irqs - i0), 16'h0);
        // A reset wake must skip the interrupt path entirely.
        i_conv_enabled = 1'b0;
        r0 = rvs;
        c0 = convs;
        pm.do_sleep(3'h1, 1'b1);
        chk(16'(convs - c0), 16'h0);
        i_any_reset = 1'b1;
        @(negedge i_clk);
        chk(16'({o_sleeping, o_core_hold}), 16'h0);
        i_any_reset = 1'b0;
        @(negedge i_clk);
        chk(16'(rvs - r0), 16'h1);
        chk(16'(irqs - i0), 16'h0);
        print_verdict();
    end
endmodule
